// File: core/spi_port_regs.svh
// Register addresses, field positions, reset values and timing counts of the SPI port.
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH

// ----------------------------------------------------------------
// Device register addresses
// ----------------------------------------------------------------
`define FIFO_ADDR      7'h00
`define OPMODE_ADDR    7'h01
`define DATAMODE_ADDR  7'h02
`define BITRATE_ADDR   7'h03
`define FLAGS_ADDR     7'h28
`define THRESH_ADDR    7'h3C

// ----------------------------------------------------------------
// Device fields and codes
// ----------------------------------------------------------------
`define MODE_MSB       4
`define MODE_LSB       2
`define MODE_SLEEP     3'h0
`define MODE_STBY      3'h1
`define MODE_TX        3'h3
`define MODE_RX        3'h4
`define CONT_BIT       6
`define THR_MSB        6
`define FL_FULL        7
`define FL_NEMPTY      6
`define FL_LEVEL       5
`define FL_OVR         4
`define FL_SENT        3
`define FL_SETTLED     2
`define WNR_BIT        7
`define REG_RESET      8'h00
`define THRESH_RESET   8'h0F
`define BITRATE_RESET  8'h07
`define LAST_BIT       3'h7

// ----------------------------------------------------------------
// Host controller registers and link timing
// ----------------------------------------------------------------
`define H_CMD          32'h0000_0000
`define H_DATA         32'h0000_0004
`define H_STAT         32'h0000_0008
`define ST_BUSY        0
`define ST_WAIT        1
`define CMD_CNT_LSB    8
`define CMD_CNT_MSB    15
`define PCLK_NS        100
`define SCK_PERIOD_NS  800
`define SCK_HALF_CYC   (`SCK_PERIOD_NS / (2 * `PCLK_NS))

`endif

// File: core/spi_port_pkg.sv
// Shared types of the SPI register port and its host controller.
package spi_port_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [6:0] addr_t;
	typedef enum logic [2:0] {H_IDLE, H_LEAD, H_SHIFT, H_WAIT, H_TRAIL} host_state_e;
endpackage

// File: core/spi_link_if.sv
// Four-wire SPI link between the host controller and the register port.
`timescale 1ns/1ns
interface spi_link_if;
	logic sck;
	logic nss_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	modport device (input sck, input nss_n, input mosi, output miso, output miso_oe);
	modport host (output sck, output nss_n, output mosi, input miso, input miso_oe);
endinterface

// File: core/byte_queue.sv
// Byte-wide first-in first-out store with clear, count and full/empty flags.
`timescale 1ns/1ns
module byte_queue #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 66,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             clear,
	input  wire logic             push,
	input  wire logic             pop,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] head,
	output logic      [CW-1:0]    count,
	output logic                  full,
	output logic                  empty
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_q;
	logic [PW-1:0]    rd_q;
	logic [CW-1:0]    cnt_q;

	wire do_push = push & ~full;
	wire do_pop  = pop & ~empty;

	assign full  = (cnt_q == CW'(DEPTH));
	assign empty = (cnt_q == '0);
	assign count = cnt_q;
	// An empty queue shows zero, so a slot never written cannot leak onto the link.
	assign head  = empty ? '0 : mem_q[rd_q];

	always_ff @(posedge pclk) begin
		if (do_push) begin
			mem_q[wr_q] <= din;
		end
	end

	// Depth need not be a power of two, so the pointers wrap by compare.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (clear) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push) begin
				wr_q <= (wr_q == LAST) ? '0 : PW'(wr_q + 1'b1);
			end
			if (do_pop) begin
				rd_q <= (rd_q == LAST) ? '0 : PW'(rd_q + 1'b1);
			end
			cnt_q <= CW'(cnt_q + CW'(do_push) - CW'(do_pop));
		end
	end
endmodule

// File: core/spi_reg_device.sv
// Register port end: SPI slave, register file, packet queue and bit shifter.
//
// Summary of operation
// - Slave only, mode 0, full duplex.
// - Master drives on fall; device samples rise.
// - MISO changes on fall; off when deselected.
// - Address byte first: write flag, 7-bit address.
// - Data bytes follow, most significant bit first.
// - Non-queue address increments after each data byte.
// - Queue address stays fixed; bytes use queue.
// - Frame ends only when select rises.
// - Write returns register's previous value on MISO.
// - Continuous mode bypasses queue on serial pin.
// - Shifter serialises and assembles bytes, MSB first.
// - Queue holds exactly 66 bytes.
// - Data-present flag refreshed at select fall.
// - Full flag high exactly when all occupied.
// - Push into full queue sets overrun; write-one clears.
// - Frame-sent set after final packet bit.
// - Level flag re-evaluated only on queue access.
// - Level flag void after full until emptied.
// - Host waits for mode settled after sleep.
// - Queue cleared on specific mode changes and on overrun clear.
`timescale 1ns/1ns
module spi_reg_device
	import spi_port_pkg::*;
#(
	parameter int DEPTH = 66
) (
	input  wire logic pclk,
	input  wire logic presetn,
	spi_link_if.device link,
	input  wire logic modem_rx_bit,
	input  wire logic modem_rx_valid,
	input  wire logic serial_data_in,
	output logic      modem_tx_bit,
	output logic      serial_data_out,
	output logic      queue_has_data,
	output logic      queue_full,
	output logic      queue_level_hit,
	output logic      queue_overrun,
	output logic      frame_sent,
	output logic      mode_settled
);
	import spi_port_pkg::*;
	`include "spi_port_regs.svh"

	localparam int CW = $clog2(DEPTH + 1);

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [1:0] sck_s;
	logic [1:0] nss_s;
	logic [1:0] mosi_s;
	logic [1:0] din_s;
	logic       sck_d_q;
	logic       nss_d_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_s   <= '0;
			nss_s   <= 2'h3;
			mosi_s  <= '0;
			din_s   <= '0;
			sck_d_q <= 1'b0;
			nss_d_q <= 1'b1;
		end else begin
			sck_s   <= {sck_s[0], link.sck};
			nss_s   <= {nss_s[0], link.nss_n};
			mosi_s  <= {mosi_s[0], link.mosi};
			din_s   <= {din_s[0], serial_data_in};
			sck_d_q <= sck_s[1];
			nss_d_q <= nss_s[1];
		end
	end

	wire active   = ~nss_s[1];
	wire sck_rise = active & sck_s[1] & ~sck_d_q;
	wire sck_fall = active & ~sck_s[1] & sck_d_q;
	wire nss_fall = nss_d_q & ~nss_s[1];

	// ----------------------------------------------------------------
	// Frame decoding
	// ----------------------------------------------------------------
	logic [2:0] bit_cnt_q;
	byte_t      in_q;
	logic       addr_phase_q;
	logic       wnr_q;
	addr_t      addr_q;
	byte_t      out_q;
	logic       miso_q;
	byte_t      regs_q [128];

	wire byte_t in_byte   = {in_q[6:0], mosi_s[1]};
	wire        byte_done = sck_rise & (bit_cnt_q == `LAST_BIT);
	wire        data_done = byte_done & ~addr_phase_q;
	wire        at_fifo   = (addr_q == `FIFO_ADDR);
	wire        wr_done   = data_done & wnr_q;
	wire        host_push = wr_done & at_fifo;
	wire        host_pop  = data_done & ~wnr_q & at_fifo;
	wire        reg_wr    = wr_done & ~at_fifo;

	// Queue access keeps its address; everything else walks forward.
	wire addr_t next_addr = addr_phase_q ? in_byte[6:0] :
		(at_fifo ? addr_q : addr_t'(addr_q + 1'b1));

	// Mode and configuration decode.
	wire [2:0] cur_mode = regs_q[`OPMODE_ADDR][`MODE_MSB:`MODE_LSB];
	wire [2:0] new_mode = in_byte[`MODE_MSB:`MODE_LSB];
	wire       mode_wr  = reg_wr & (addr_q == `OPMODE_ADDR) & (new_mode != cur_mode);
	wire       is_tx    = (cur_mode == `MODE_TX);
	wire       is_rx    = (cur_mode == `MODE_RX);
	wire       cont     = regs_q[`DATAMODE_ADDR][`CONT_BIT];
	wire [6:0] thresh   = regs_q[`THRESH_ADDR][`THR_MSB:0];
	wire       ovr_clr  = reg_wr & (addr_q == `FLAGS_ADDR) & in_byte[`FL_OVR];

	// Receive entered from rest, receive to transmit, and any exit from transmit.
	wire from_rest  = (cur_mode == `MODE_SLEEP) | (cur_mode == `MODE_STBY);
	wire mode_clear = mode_wr & (((new_mode == `MODE_RX) & from_rest) |
		(is_rx & (new_mode == `MODE_TX)) | is_tx);

	// ----------------------------------------------------------------
	// Packet queue and bit shifter
	// ----------------------------------------------------------------
	byte_t       q_head;
	logic [CW-1:0] q_count;
	logic        q_full;
	logic        q_empty;
	byte_t       sh_q;
	logic [2:0]  sh_cnt_q;
	byte_t       baud_q;
	logic        sh_busy_q;
	logic        tx_bit_q;
	logic        sdo_q;

	wire sh_load  = ~sh_busy_q & is_tx & ~cont & ~q_empty;
	wire baud_hit = sh_busy_q & (baud_q == '0);
	wire sh_end   = baud_hit & (sh_cnt_q == '0);
	wire rx_take  = modem_rx_valid & is_rx & ~cont;
	wire sr_push  = rx_take & (sh_cnt_q == `LAST_BIT);
	wire q_push   = host_push | sr_push;
	wire q_pop    = host_pop | sh_load;
	wire q_clear  = ovr_clr | mode_clear;
	wire byte_t q_din = sr_push ? {sh_q[6:0], modem_rx_bit} : in_byte;

	byte_queue #(
		.WIDTH (8),
		.DEPTH (DEPTH)
	) u_queue (
		.pclk    (pclk),
		.presetn (presetn),
		.clear   (q_clear),
		.push    (q_push),
		.pop     (q_pop),
		.din     (q_din),
		.head    (q_head),
		.count   (q_count),
		.full    (q_full),
		.empty   (q_empty)
	);

	// Flags byte as seen at the flags address.
	byte_t flags_byte;
	always_comb begin
		flags_byte = '0;
		flags_byte[`FL_FULL]    = q_full;
		flags_byte[`FL_NEMPTY]  = queue_has_data;
		flags_byte[`FL_LEVEL]   = queue_level_hit;
		flags_byte[`FL_OVR]     = queue_overrun;
		flags_byte[`FL_SENT]    = frame_sent;
		flags_byte[`FL_SETTLED] = mode_settled;
	end

	wire byte_t rd_val = at_fifo ? q_head :
		((addr_q == `FLAGS_ADDR) ? flags_byte : regs_q[addr_q]);

	// ----------------------------------------------------------------
	// Serial engine
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt_q    <= '0;
			in_q         <= '0;
			addr_phase_q <= 1'b1;
			wnr_q        <= 1'b0;
			addr_q       <= '0;
			out_q        <= '0;
			miso_q       <= 1'b0;
		end else if (!active) begin
			bit_cnt_q    <= '0;
			addr_phase_q <= 1'b1;
		end else begin
			if (sck_rise) begin
				in_q      <= in_byte;
				bit_cnt_q <= 3'(bit_cnt_q + 1'b1);
			end
			if (byte_done) begin
				addr_phase_q <= 1'b0;
				addr_q       <= next_addr;
				if (addr_phase_q) begin
					wnr_q <= in_byte[`WNR_BIT];
				end
			end
			// The old value is loaded at the fall that closes the previous byte, before this byte's write lands at its last rise.
			if (sck_fall && bit_cnt_q == '0 && !addr_phase_q) begin
				miso_q <= rd_val[7];
				out_q  <= {rd_val[6:0], 1'b0};
			end else if (sck_fall) begin
				miso_q <= out_q[7];
				out_q  <= {out_q[6:0], 1'b0};
			end
		end
	end

	assign link.miso    = miso_q;
	assign link.miso_oe = active;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 128; i++) begin
				regs_q[i] <= `REG_RESET;
			end
			regs_q[`THRESH_ADDR]  <= `THRESH_RESET;
			regs_q[`BITRATE_ADDR] <= `BITRATE_RESET;
		end else if (reg_wr) begin
			regs_q[addr_q] <= in_byte;
		end
	end

	// ----------------------------------------------------------------
	// Shifter between queue and modem
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_q      <= '0;
			sh_cnt_q  <= '0;
			baud_q    <= '0;
			sh_busy_q <= 1'b0;
			tx_bit_q  <= 1'b0;
			sdo_q     <= 1'b0;
		end else if (cont) begin
			if (is_tx) begin
				tx_bit_q <= din_s[1];
			end
			if (is_rx && modem_rx_valid) begin
				sdo_q <= modem_rx_bit;
			end
		end else if (sh_load) begin
			tx_bit_q  <= q_head[7];
			sh_q      <= {q_head[6:0], 1'b0};
			sh_cnt_q  <= `LAST_BIT;
			baud_q    <= regs_q[`BITRATE_ADDR];
			sh_busy_q <= 1'b1;
		end else if (sh_end) begin
			sh_busy_q <= 1'b0;
			sh_cnt_q  <= '0;
		end else if (baud_hit) begin
			tx_bit_q <= sh_q[7];
			sh_q     <= {sh_q[6:0], 1'b0};
			sh_cnt_q <= 3'(sh_cnt_q - 1'b1);
			baud_q   <= regs_q[`BITRATE_ADDR];
		end else if (sh_busy_q) begin
			baud_q <= 8'(baud_q - 1'b1);
		end else if (rx_take) begin
			sh_q     <= {sh_q[6:0], modem_rx_bit};
			sh_cnt_q <= 3'(sh_cnt_q + 1'b1);
		end
	end

	assign modem_tx_bit    = tx_bit_q;
	assign serial_data_out = sdo_q;

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	logic hd_q;
	logic lvl_q;
	logic lvl_ok_q;
	logic upd_q;
	logic ovr_q;
	logic sent_q;
	logic settled_q;

	wire ovr_set  = q_push & q_full;
	wire sent_set = sh_end & q_empty;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hd_q      <= 1'b0;
			lvl_q     <= 1'b0;
			lvl_ok_q  <= 1'b1;
			upd_q     <= 1'b0;
			ovr_q     <= 1'b0;
			sent_q    <= 1'b0;
			settled_q <= 1'b1;
		end else begin
			// During a read frame the flag only moves at select fall or on a push.
			if (q_clear) begin
				hd_q <= 1'b0;
			end else if (nss_fall || !active) begin
				hd_q <= ~q_empty;
			end else if (q_push) begin
				hd_q <= 1'b1;
			end
			upd_q <= q_push | q_pop | q_clear;
			if (upd_q) begin
				lvl_q <= (q_count > CW'(thresh));
			end
			if (q_full) begin
				lvl_ok_q <= 1'b0;
			end else if (q_empty) begin
				lvl_ok_q <= 1'b1;
			end
			ovr_q  <= ovr_set | (ovr_q & ~ovr_clr);
			sent_q <= sent_set | (sent_q & ~(mode_wr | sh_load));
			// Leaving transmit waits for the byte in flight to finish.
			settled_q <= ~mode_wr & (settled_q | ~sh_busy_q);
		end
	end

	assign queue_has_data  = hd_q;
	assign queue_full      = q_full;
	assign queue_level_hit = lvl_q & lvl_ok_q;
	assign queue_overrun   = ovr_q;
	assign frame_sent      = sent_q;
	assign mode_settled    = settled_q;
endmodule

// File: core/spi_host_ctrl.sv
// Host end: APB-programmed SPI master that frames address and data bytes.
`timescale 1ns/1ns
`include "spi_port_regs.svh"
module spi_host_ctrl
	import spi_port_pkg::*;
#(
	parameter int HALF = `SCK_HALF_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	spi_link_if.host         link
);
	import spi_port_pkg::*;

	localparam int HW = $clog2(HALF + 1);

	host_state_e state_q;
	byte_t       cmd_q;
	byte_t       remain_q;
	byte_t       tx_q;
	byte_t       rx_q;
	byte_t       sh_q;
	logic        data_ok_q;
	logic [2:0]  bits_q;
	logic [HW-1:0] half_q;
	logic        sck_q;
	logic        nss_q;
	logic        mosi_q;
	logic [1:0]  miso_s;
	logic [31:0] prdata_q;

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	wire access  = psel & penable;
	wire hit_cmd = (paddr == `H_CMD);
	wire hit_dat = (paddr == `H_DATA);
	wire hit_st  = (paddr == `H_STAT);
	wire mapped  = hit_cmd | hit_dat | hit_st;
	wire cmd_wr  = access & pwrite & hit_cmd & (state_q == H_IDLE);
	wire data_wr = access & pwrite & hit_dat;
	wire waiting = (state_q == H_WAIT) & (remain_q != '0) & ~data_ok_q;
	wire tick    = (half_q == '0);
	wire take    = (state_q == H_WAIT) & (remain_q != '0) & data_ok_q;

	logic [31:0] status;
	always_comb begin
		status = '0;
		status[`ST_BUSY] = (state_q != H_IDLE);
		status[`ST_WAIT] = waiting;
	end

	wire [31:0] rd_mux = hit_cmd ? {16'h0000, remain_q, cmd_q} :
		(hit_dat ? {24'h00_0000, rx_q} : (hit_st ? status : '0));

	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata  = prdata_q;

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= H_IDLE;
			cmd_q     <= '0;
			remain_q  <= '0;
			tx_q      <= '0;
			rx_q      <= '0;
			sh_q      <= '0;
			data_ok_q <= 1'b0;
			bits_q    <= '0;
			half_q    <= '0;
			sck_q     <= 1'b0;
			nss_q     <= 1'b1;
			mosi_q    <= 1'b0;
			miso_s    <= '0;
			prdata_q  <= '0;
		end else begin
			miso_s <= {miso_s[0], link.miso};
			if (psel && !penable) begin
				prdata_q <= rd_mux;
			end
			if (data_wr) begin
				tx_q <= pwdata[7:0];
			end
			data_ok_q <= data_wr | (data_ok_q & ~take);
			half_q    <= (tick || state_q == H_IDLE) ? HW'(HALF - 1) : HW'(half_q - 1'b1);
			case (state_q)
				H_IDLE: begin
					nss_q <= 1'b1;
					if (cmd_wr) begin
						cmd_q    <= pwdata[7:0];
						remain_q <= pwdata[`CMD_CNT_MSB:`CMD_CNT_LSB];
						sh_q     <= pwdata[7:0];
						mosi_q   <= pwdata[`WNR_BIT];
						nss_q    <= 1'b0;
						state_q  <= H_LEAD;
					end
				end
				H_LEAD: begin
					if (tick) begin
						bits_q  <= '0;
						state_q <= H_SHIFT;
					end
				end
				H_SHIFT: begin
					if (tick && !sck_q) begin
						sck_q <= 1'b1;
					end else if (tick) begin
						sck_q  <= 1'b0;
						sh_q   <= {sh_q[6:0], miso_s[1]};
						bits_q <= 3'(bits_q + 1'b1);
						if (bits_q == `LAST_BIT) begin
							rx_q    <= {sh_q[6:0], miso_s[1]};
							state_q <= H_WAIT;
						end else begin
							mosi_q <= sh_q[6];
						end
					end
				end
				H_WAIT: begin
					// The clock stops between bytes while software refills.
					if (remain_q == '0) begin
						state_q <= H_TRAIL;
					end else if (data_ok_q) begin
						sh_q     <= tx_q;
						mosi_q   <= tx_q[7];
						remain_q <= 8'(remain_q - 1'b1);
						state_q  <= H_SHIFT;
					end
				end
				H_TRAIL: begin
					if (tick) begin
						nss_q   <= 1'b1;
						state_q <= H_IDLE;
					end
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end

	assign link.sck   = sck_q;
	assign link.nss_n = nss_q;
	assign link.mosi  = mosi_q;
endmodule

// File: tb/spi_link_assertions.sv
// Concurrent checks on the SPI link between the host controller and the register port.
`timescale 1ns/1ns
module spi_link_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sck,
	input wire logic nss_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// Link framing and timing
	// ----------------------------------------------------------------
	a_sck_idle_low: assert property (nss_n |-> !sck)
		else $error("sck high while deselected");
	a_frame_open_low: assert property ($fell(nss_n) |-> !sck[*8] ##1 sck)
		else $error("frame did not open with a low clock then a rise");
	a_sck_high_half: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
		else $error("sck high phase not four cycles");
	a_mosi_held_high: assert property (sck |-> $stable(mosi))
		else $error("mosi moved while sck high");
	a_miso_held_rise: assert property ($rose(sck) |=> $stable(miso)[*3])
		else $error("miso moved near a rising sck");
	a_miso_off_idle: assert property (nss_n[*5] |-> !miso_oe)
		else $error("miso driven while deselected");
	a_miso_on_select: assert property (!nss_n[*5] |-> miso_oe)
		else $error("miso not driven while selected");
	a_frame_close_idle: assert property ($rose(nss_n) |-> !$past(sck))
		else $error("frame closed with sck high");

	c_frame_open: cover property ($fell(nss_n));
	c_miso_driven: cover property ($rose(miso_oe));
	c_frame_close: cover property ($rose(nss_n));
endmodule

// File: tb/spi_register_port_with_packet_fifo_test.sv
// Self-checking bench joining the host controller and the register port.
`timescale 1ns/1ns
`include "spi_port_regs.svh"
module spi_register_port_with_packet_fifo_test import spi_port_pkg::*;;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [31:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic        pready;
	logic        rx_bit = 0;
	logic        rx_valid = 0;
	logic        ser_in = 0;
	logic        tx_bit, ser_out;
	localparam byte_t RX_PAT = 8'hA5;
	logic        has_data, full, level_hit, overrun, sent, settled;
	byte_t       rxb [0:79];
	int          mismatches = 0;
	int          tests_run = 0;

	spi_link_if link ();

	spi_host_ctrl spi_host_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(), .link(link));

	spi_reg_device spi_reg_device_i (.pclk(pclk), .presetn(presetn), .link(link),
		.modem_rx_bit(rx_bit), .modem_rx_valid(rx_valid), .serial_data_in(ser_in),
		.modem_tx_bit(tx_bit), .serial_data_out(ser_out), .queue_has_data(has_data),
		.queue_full(full), .queue_level_hit(level_hit), .queue_overrun(overrun),
		.frame_sent(sent), .mode_settled(settled));

	spi_link_assertions spi_link_assertions_i (.pclk(pclk), .presetn(presetn),
		.sck(link.sck), .nss_n(link.nss_n), .mosi(link.mosi), .miso(link.miso),
		.miso_oe(link.miso_oe));

	always #50 pclk = ~pclk;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One whole frame; data byte i sent is base + i, byte i received lands in rxb.
	task automatic frame(input logic w, input addr_t a, input int n, input byte_t base);
		logic [31:0] q;
		apb(1'b1, `H_CMD, {16'h0000, n[7:0], w, a}, q);
		for (int i = 0; i < n; i++) begin
			apb(1'b1, `H_DATA, {24'h00_0000, base + i[7:0]}, q);
			do apb(1'b0, `H_STAT, 32'h0000_0000, q); while (q[`ST_WAIT] === 1'b1);
			do apb(1'b0, `H_STAT, 32'h0000_0000, q);
			while (q[`ST_WAIT] !== 1'b1 && q[`ST_BUSY] !== 1'b0);
			apb(1'b0, `H_DATA, 32'h0000_0000, q);
			rxb[i] = q[7:0];
		end
		do apb(1'b0, `H_STAT, 32'h0000_0000, q); while (q[`ST_BUSY] !== 1'b0);
		// The port sees the select rise through its two-flop synchroniser.
		repeat (4) @(posedge pclk);
	endtask

	task automatic stop_test;
		if (mismatches == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_read;
		frame(1'b0, `THRESH_ADDR, 1, 8'h00);
		chk(rxb[0], `THRESH_RESET);
		chk({7'h00, settled}, 8'h01);
		chk({7'h00, has_data}, 8'h00);
	endtask

	task automatic t_burst;
		frame(1'b1, `DATAMODE_ADDR, 2, 8'h00);
		chk(rxb[0], `REG_RESET);
		chk(rxb[1], `BITRATE_RESET);
		frame(1'b0, `DATAMODE_ADDR, 2, 8'h00);
		chk(rxb[0], 8'h00);
		chk(rxb[1], 8'h01);
	endtask

	task automatic t_queue_order;
		frame(1'b1, `FIFO_ADDR, 3, 8'hC1);
		chk({7'h00, has_data}, 8'h01);
		frame(1'b0, `FIFO_ADDR, 3, 8'h00);
		for (int i = 0; i < 3; i++) chk(rxb[i], 8'hC1 + i[7:0]);
		chk({7'h00, has_data}, 8'h00);
	endtask

	task automatic t_fill_level;
		frame(1'b1, `OPMODE_ADDR, 1, 8'h04);
		frame(1'b1, `FIFO_ADDR, 16, 8'h10);
		chk({7'h00, level_hit}, 8'h01);
		frame(1'b1, `THRESH_ADDR, 1, 8'h7F);
		chk({7'h00, level_hit}, 8'h01);
		frame(1'b1, `FIFO_ADDR, 49, 8'h20);
		chk({7'h00, full}, 8'h00);
		// A low threshold makes the level flag want to rise as the queue fills.
		frame(1'b1, `THRESH_ADDR, 1, `THRESH_RESET);
		frame(1'b1, `FIFO_ADDR, 1, 8'h60);
		chk({7'h00, full}, 8'h01);
		chk({7'h00, level_hit}, 8'h00);
		frame(1'b1, `FIFO_ADDR, 1, 8'hEE);
		chk({7'h00, overrun}, 8'h01);
		frame(1'b1, `FLAGS_ADDR, 1, 8'h10);
		chk({5'h00, overrun, full, has_data}, 8'h00);
		frame(1'b1, `THRESH_ADDR, 1, 8'h00);
		frame(1'b1, `FIFO_ADDR, 1, 8'h5A);
		chk({7'h00, level_hit}, 8'h01);
	endtask

	task automatic t_tx_then_rx;
		frame(1'b1, `FIFO_ADDR, 1, 8'h81);
		frame(1'b1, `OPMODE_ADDR, 1, 8'h0C);
		for (int i = 0; i < 400 && sent !== 1'b1; i++) @(posedge pclk);
		chk({7'h00, sent}, 8'h01);
		// A slow bit rate keeps the second byte queued until the mode change.
		frame(1'b1, `BITRATE_ADDR, 1, 8'hFF);
		frame(1'b1, `FIFO_ADDR, 2, 8'h30);
		chk({7'h00, tx_bit}, 8'h00);
		frame(1'b1, `OPMODE_ADDR, 1, 8'h10);
		chk({7'h00, has_data}, 8'h00);
		for (int i = 0; i < 3000 && settled !== 1'b1; i++) @(posedge pclk);
		chk({7'h00, settled}, 8'h01);
		for (int i = 7; i >= 0; i--) begin
			@(posedge pclk);
			rx_bit <= RX_PAT[i];
			rx_valid <= 1'b1;
			@(posedge pclk);
			rx_valid <= 1'b0;
			repeat (3) @(posedge pclk);
		end
		chk({7'h00, has_data}, 8'h01);
		frame(1'b1, `OPMODE_ADDR, 1, 8'h00);
		for (int i = 0; i < 50 && settled !== 1'b1; i++) @(posedge pclk);
		chk({7'h00, settled}, 8'h01);
		frame(1'b0, `FIFO_ADDR, 1, 8'h00);
		chk(rxb[0], RX_PAT);
	endtask

	task automatic t_continuous;
		frame(1'b1, `DATAMODE_ADDR, 1, 8'h40);
		frame(1'b1, `OPMODE_ADDR, 1, 8'h0C);
		ser_in <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({7'h00, tx_bit}, 8'h01);
		ser_in <= 1'b0;
		repeat (4) @(posedge pclk);
		chk({7'h00, tx_bit}, 8'h00);
		frame(1'b1, `OPMODE_ADDR, 1, 8'h10);
		for (int i = 1; i >= 0; i--) begin
			rx_bit <= i[0];
			rx_valid <= 1'b1;
			@(posedge pclk);
			rx_valid <= 1'b0;
			repeat (2) @(posedge pclk);
			chk({7'h00, ser_out}, {7'h00, i[0]});
		end
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_read();
		t_burst();
		t_queue_order();
		t_fill_level();
		t_tx_then_rx();
		t_continuous();
		stop_test();
	end

	// A hang costs one mismatch and closes the run the normal way.
	initial begin
		repeat (80000) @(posedge pclk);
		mismatches++;
		stop_test();
	end
endmodule
